// >>> rtl/pra_pkg.sv
/*
  Constants for the predicate and reciprocal ALU slot: instruction field
  positions, opcodes, float encodings and reset values.
  Assumes a 32-bit operand path and the two-word two-operand ALU format.
*/
package pra_pkg;

  // Field positions in the control word (+4)
  localparam int OPC_LSB  = 7;
  localparam int OPC_W    = 11;
  localparam int DST_LSB  = 21;
  localparam int DST_W    = 7;
  // Field position in the operand select word (+0)
  localparam int LAST_BIT = 31;

  // Opcodes of this group
  typedef enum logic [10:0] {
    PRA_UINT_GT_PREDICATE_SET    = 11'h01e,
    PRA_FLOAT_NE_PREDICATE_SET   = 11'h023,
    PRA_FLOAT_GT_COUNTER_PUSH    = 11'h029,
    PRA_FLOAT_NE_COUNTER_PUSH    = 11'h02b,
    PRA_INT_GT_PREDICATE_SET     = 11'h043,
    PRA_INT_NE_PREDICATE_SET     = 11'h045,
    PRA_INT_GT_COUNTER_PUSH      = 11'h04b,
    PRA_INT_NE_COUNTER_PUSH      = 11'h04d,
    PRA_INT_LT_COUNTER_PUSH      = 11'h04e,
    PRA_INT_LE_COUNTER_PUSH      = 11'h04f,
    PRA_SINGLE_RECIPROCAL_CLAMP  = 11'h084,
    PRA_SINGLE_RECIPROCAL_ZERO_CLAMP = 11'h085,
    PRA_SINGLE_RECIPROCAL_IEEE   = 11'h086,
    PRA_DOUBLE_RECIPROCAL        = 11'h095,
    PRA_DOUBLE_RECIPROCAL_CLAMP  = 11'h096,
    PRA_DOUBLE_RECIP_SQRT        = 11'h097
  } pra_opc_t;

  // Reciprocal unit modes
  typedef enum logic [1:0] {
    PRA_RM_SINGLE = 2'b00,
    PRA_RM_DOUBLE = 2'b01,
    PRA_RM_DRSQRT = 2'b10
  } pra_rmode_t;

  // Float encodings
  localparam logic [31:0] F_ZERO     = 32'h0000_0000;
  localparam logic [31:0] F_ONE      = 32'h3f80_0000;
  localparam logic [30:0] F_INF_MAG  = 31'h7f80_0000;
  localparam logic [30:0] F_MAX_MAG  = 31'h7f7f_ffff;
  localparam logic [31:0] F_QNAN     = 32'h7fc0_0000;
  localparam logic [31:0] D_ONE_HI   = 32'h3ff0_0000;
  localparam logic [30:0] D_INF_MAG  = 31'h7ff0_0000;
  localparam logic [30:0] D_MAX_MAG  = 31'h7fef_ffff;
  localparam logic [31:0] D_QNAN_HI  = 32'h7ff8_0000;
  // Exponent and mantissa figures for the estimates
  localparam logic [8:0]  F_EXP_ONE  = 9'h0fe;
  localparam logic [8:0]  F_EXP_FRAC = 9'h0fd;
  localparam logic [11:0] D_EXP_ONE  = 12'h7fe;
  localparam logic [11:0] D_EXP_FRAC = 12'h7fd;
  localparam logic [12:0] D_EXP_RSQ  = 13'h0bfd;
  localparam logic [19:0] D_RSQ_ODD  = 20'h6a09e;
  // Counter increment range (below 2^24 stays exact)
  localparam logic [7:0]  F_EXP_BIAS = 8'h7f;
  localparam logic [7:0]  F_EXP_BIG  = 8'h97;
  localparam logic [7:0]  F_EXP_LSB0 = 8'h96;

  // Reset values
  localparam logic [31:0] DST_RST    = 32'h0000_0000;
  localparam logic [6:0]  GPR_RST    = 7'h00;

endpackage : pra_pkg

// >>> rtl/pra_recip_unit.sv
/*
  Reciprocal and reciprocal square root estimate, combinational.
  Single mode works on hi_i; double modes take the high dword in hi_i and
  the low dword in lo_i and return only the high result dword.
  Assumes the caller registers the result and applies any clamping.
*/
`timescale 1ns/1ps
`default_nettype none
module pra_recip_unit
  import pra_pkg::*;
(
  input  wire pra_pkg::pra_rmode_t mode_i,
  input  wire logic [31:0]         hi_i,
  input  wire logic [31:0]         lo_i,
  output logic [31:0]              res_o
);
  import pra_pkg::*;

  logic        sgn;
  logic [7:0]  fe;
  logic [22:0] fm;
  logic [10:0] de;
  logic [19:0] dm;
  logic        dm_nz;
  logic [8:0]  fex;
  logic [11:0] dex;
  logic [12:0] rsq;

  // Reciprocal estimate: exponent negated, mantissa taken as one minus fraction; rsqrt halves the negated exponent
  always_comb begin
    sgn   = hi_i[31];
    fe    = hi_i[30:23];
    fm    = hi_i[22:0];
    de    = hi_i[30:20];
    dm    = hi_i[19:0];
    dm_nz = (dm != 20'h0) || (lo_i != 32'h0);
    fex   = (fm == 23'h0) ? F_EXP_ONE - {1'b0, fe} : F_EXP_FRAC - {1'b0, fe};
    dex   = (!dm_nz) ? D_EXP_ONE - {1'b0, de} : D_EXP_FRAC - {1'b0, de};
    rsq   = D_EXP_RSQ - {2'b00, de};
    res_o = F_ZERO;
    case (mode_i)
      PRA_RM_SINGLE: begin
        if (hi_i == F_ONE) res_o = F_ONE;
        else if (fe == 8'hff) res_o = (fm != 23'h0) ? F_QNAN : {sgn, 31'h0};
        else if (fe == 8'h00) res_o = {sgn, F_INF_MAG};
        else if (fex[8] || fex == 9'h0) res_o = {sgn, 31'h0};
        else if (fm == 23'h0) res_o = {sgn, fex[7:0], 23'h0};
        else res_o = {sgn, fex[7:0], ~fm};
      end
      PRA_RM_DOUBLE: begin
        if (hi_i == D_ONE_HI && lo_i == 32'h0) res_o = D_ONE_HI;
        else if (de == 11'h7ff) res_o = dm_nz ? D_QNAN_HI : {sgn, 31'h0};
        else if (de == 11'h000) res_o = {sgn, D_INF_MAG};
        else if (dex[11] || dex == 12'h0) res_o = {sgn, 31'h0};
        else if (!dm_nz) res_o = {sgn, dex[10:0], 20'h0};
        else res_o = {sgn, dex[10:0], ~dm};
      end
      PRA_RM_DRSQRT: begin
        if (hi_i == D_ONE_HI && lo_i == 32'h0) res_o = D_ONE_HI;
        else if (de == 11'h7ff && dm_nz) res_o = D_QNAN_HI;
        else if (de == 11'h000) res_o = {sgn, D_INF_MAG};
        else if (sgn) res_o = D_QNAN_HI;
        else if (de == 11'h7ff) res_o = 32'h0;
        else res_o = {1'b0, rsq[11:1], rsq[0] ? D_RSQ_ODD - {2'b00, dm[19:2]} : ~{1'b0, dm[19:1]}};
      end
      default: res_o = F_ZERO;
    endcase
  end
endmodule : pra_recip_unit
`default_nettype wire

// >>> rtl/pra_alu_slot.sv
/*
  One ALU slot for the predicate-set, counter-push and reciprocal group.
  Decodes the two-word instruction, computes the destination value and the
  execute/skip predicate result, and registers them one cycle later.
  Assumes the sequencer presents both words and the resolved operands in
  the same cycle as valid_i, and writes back what this slot returns.
*/
// How it works
// - Float gt push: src1>0 and src0==0 gives 0.0/execute, else src0.W+1/skip.
// - Int gt push: signed src1>0 and src0==0.0 gives 0.0/execute, else src0+1/skip.
// - Unsigned gt set: src0>src1 unsigned gives 0.0/execute, else 1.0/skip.
// - Opcode 67 in the control word selects signed gt predicate set.
// - Int le push: src1<=0 and src0==0.0 gives 0.0/execute, else src0+1/skip.
// - Int lt push: src1<0 and src0==0.0 gives 0.0/execute, else src0+1/skip.
// - Float ne set: differing floats give 0.0/execute, else 1.0/skip.
// - Int ne set: differing words give 0.0/execute, else 1.0/skip.
// - Float ne push: src1!=0 and src0==0.0 gives 0.0/execute, else src0+1/skip.
// - Int ne push: src1!=0 and src0==0.0 gives 0.0/execute, else src0+1/skip.
// - Double reciprocal of src0:src1, exact 1.0 for 1.0, high dword only.
// - Single clamped reciprocal: infinities become signed largest finite float.
// - Double clamped reciprocal: infinities become signed largest finite double.
// - Single zero-clamped reciprocal: infinities become signed zero.
// - Single reciprocal estimate, exact 1.0 for 1.0, no clamping.
// - Double reciprocal square root of src0:src1, exact 1.0, high dword only.
// - Instruction is two words: operand selects at +0, control at +4.
// - Signed gt set: src0>src1 signed gives 0.0/execute, else 1.0/skip.
`timescale 1ns/1ps
`default_nettype none
module pra_alu_slot
  import pra_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        valid_i,
  input  wire logic [31:0] operand_select_word_i,
  input  wire logic [31:0] two_operand_control_word_i,
  input  wire logic [31:0] src0_i,
  input  wire logic [31:0] src1_i,
  input  wire logic [31:0] src0_w_i,
  output logic             valid_o,
  output logic [31:0]      dst_o,
  output logic [6:0]       dst_gpr_o,
  output logic             last_o,
  output logic             pred_wr_o,
  output logic             pred_exec_o,
  output logic             illegal_o
);
  import pra_pkg::*;

  // Zero or denormal, denormals behave as zero
  function automatic logic f_zero(input logic [31:0] a);
    f_zero = (a[30:23] == 8'h00);
  endfunction : f_zero

  function automatic logic f_nan(input logic [31:0] a);
    f_nan = (a[30:23] == 8'hff) && (a[22:0] != 23'h0);
  endfunction : f_nan

  // Ordered equality, signed zeros equal
  function automatic logic f_eq(input logic [31:0] a, input logic [31:0] b);
    f_eq = !f_nan(a) && !f_nan(b) && ((f_zero(a) && f_zero(b)) || a == b);
  endfunction : f_eq

  // Ordered greater-than, false on any NaN
  function automatic logic f_gt(input logic [31:0] a, input logic [31:0] b);
    logic [30:0] ma;
    logic [30:0] mb;
    logic        sa;
    logic        sb;
    ma = f_zero(a) ? 31'h0 : a[30:0];
    mb = f_zero(b) ? 31'h0 : b[30:0];
    sa = a[31] && (ma != 31'h0);
    sb = b[31] && (mb != 31'h0);
    if (f_nan(a) || f_nan(b)) f_gt = 1'b0;
    else if (sa != sb) f_gt = sb;
    else if (sa) f_gt = ma < mb;
    else f_gt = ma > mb;
  endfunction : f_gt

  // Counter increment: integer part plus 1.0, exact below 2^24
  function automatic logic [31:0] f_inc(input logic [31:0] a);
    logic [24:0] v;
    logic [24:0] sh;
    logic [4:0]  p;
    logic [7:0]  sft;
    v   = 25'h0;
    sh  = 25'h0;
    p   = 5'd0;
    sft = F_EXP_LSB0 - a[30:23];
    if (f_zero(a)) f_inc = F_ONE;
    else if (a[31] || a[30:23] == 8'hff || a[30:23] >= F_EXP_BIG) f_inc = a;
    else begin
      if (a[30:23] >= F_EXP_BIAS) v = {1'b0, 1'b1, a[22:0]} >> sft;
      v = v + 25'd1;
      for (int i = 0; i < 25; i++) begin
        if (v[i]) p = 5'(i);
      end
      sh    = v << (5'd24 - p);
      f_inc = {1'b0, 8'(F_EXP_BIAS + {3'b000, p}), sh[23:1]};
    end
  endfunction : f_inc

  pra_opc_t    opc;
  pra_rmode_t  rmode;
  logic [31:0] rcp;
  logic        push_hit;
  logic        push_op;
  logic        is_pred;
  logic        cond;
  logic [31:0] inc_src;
  logic        valid_r, valid_nxt;
  logic [31:0] dst_r, dst_nxt;
  logic [6:0]  gpr_r, gpr_nxt;
  logic        last_r, last_nxt;
  logic        pwr_r, pwr_nxt;
  logic        pex_r, pex_nxt;
  logic        ill_r, ill_nxt;

  // Opcode from the +4 word, last flag from the +0 word
  assign opc = pra_opc_t'(two_operand_control_word_i[OPC_LSB +: OPC_W]);

  // Reciprocal estimate shared by all reciprocal opcodes
  always_comb begin
    case (opc)
      PRA_DOUBLE_RECIPROCAL, PRA_DOUBLE_RECIPROCAL_CLAMP: rmode = PRA_RM_DOUBLE;
      PRA_DOUBLE_RECIP_SQRT: rmode = PRA_RM_DRSQRT;
      default: rmode = PRA_RM_SINGLE;
    endcase
  end

  pra_recip_unit u_recip (
    .mode_i (rmode),
    .hi_i   (src0_i),
    .lo_i   (src1_i),
    .res_o  (rcp)
  );

  // Compare condition and operation class
  always_comb begin
    cond    = 1'b0;
    push_op = 1'b0;
    is_pred = 1'b1;
    ill_nxt = 1'b0;
    inc_src = src0_i;
    case (opc)
      PRA_UINT_GT_PREDICATE_SET:  cond = src0_i > src1_i;
      PRA_FLOAT_NE_PREDICATE_SET: cond = !f_eq(src0_i, src1_i);
      PRA_INT_GT_PREDICATE_SET:   cond = $signed(src0_i) > $signed(src1_i);
      PRA_INT_NE_PREDICATE_SET:   cond = src0_i != src1_i;
      PRA_FLOAT_GT_COUNTER_PUSH: begin
        push_op = 1'b1;
        inc_src = src0_w_i;
        cond    = f_gt(src1_i, F_ZERO);
      end
      PRA_FLOAT_NE_COUNTER_PUSH: begin
        push_op = 1'b1;
        cond    = !f_eq(src1_i, F_ZERO);
      end
      PRA_INT_GT_COUNTER_PUSH: begin
        push_op = 1'b1;
        cond    = $signed(src1_i) > 0;
      end
      PRA_INT_NE_COUNTER_PUSH: begin
        push_op = 1'b1;
        cond    = src1_i != 32'h0;
      end
      PRA_INT_LT_COUNTER_PUSH: begin
        push_op = 1'b1;
        cond    = src1_i[31];
      end
      PRA_INT_LE_COUNTER_PUSH: begin
        push_op = 1'b1;
        cond    = src1_i[31] || src1_i == 32'h0;
      end
      PRA_SINGLE_RECIPROCAL_CLAMP, PRA_SINGLE_RECIPROCAL_ZERO_CLAMP, PRA_SINGLE_RECIPROCAL_IEEE,
      PRA_DOUBLE_RECIPROCAL, PRA_DOUBLE_RECIPROCAL_CLAMP, PRA_DOUBLE_RECIP_SQRT: is_pred = 1'b0;
      default: begin
        is_pred = 1'b0;
        ill_nxt = valid_i;
      end
    endcase
    push_hit = cond && f_eq(src0_i, F_ZERO);
  end

  // Destination value and predicate result
  always_comb begin
    valid_nxt = valid_i && !ill_nxt;
    gpr_nxt   = two_operand_control_word_i[DST_LSB +: DST_W];
    last_nxt  = valid_i && operand_select_word_i[LAST_BIT];
    pwr_nxt   = valid_i && is_pred;
    pex_nxt   = 1'b0;
    dst_nxt   = F_ZERO;
    if (push_op) begin
      pex_nxt = push_hit;
      dst_nxt = push_hit ? F_ZERO : f_inc(inc_src);
    end else if (is_pred) begin
      pex_nxt = cond;
      dst_nxt = cond ? F_ZERO : F_ONE;
    end else begin
      dst_nxt = rcp;
      if (opc == PRA_SINGLE_RECIPROCAL_CLAMP && rcp[30:0] == F_INF_MAG)
        dst_nxt = {rcp[31], F_MAX_MAG};
      if (opc == PRA_SINGLE_RECIPROCAL_ZERO_CLAMP && rcp[30:0] == F_INF_MAG)
        dst_nxt = {rcp[31], 31'h0};
      if (opc == PRA_DOUBLE_RECIPROCAL_CLAMP && rcp[30:0] == D_INF_MAG)
        dst_nxt = {rcp[31], D_MAX_MAG};
    end
    if (!valid_i) dst_nxt = dst_r;
    if (!valid_i) gpr_nxt = gpr_r;
    if (!valid_i) pex_nxt = 1'b0;                                                // No stale execute while idle
  end

  // Result registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_r <= 1'b0;
      dst_r   <= DST_RST;
      gpr_r   <= GPR_RST;
      last_r  <= 1'b0;
      pwr_r   <= 1'b0;
      pex_r   <= 1'b0;
      ill_r   <= 1'b0;
    end else begin
      valid_r <= valid_nxt;
      dst_r   <= dst_nxt;
      gpr_r   <= gpr_nxt;
      last_r  <= last_nxt;
      pwr_r   <= pwr_nxt;
      pex_r   <= pex_nxt;
      ill_r   <= ill_nxt;
    end
  end

  assign valid_o     = valid_r;
  assign dst_o       = dst_r;
  assign dst_gpr_o   = gpr_r;
  assign last_o      = last_r;
  assign pred_wr_o   = pwr_r;
  assign pred_exec_o = pex_r;
  assign illegal_o   = ill_r;

  // Checks on the registered results
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_fgt_push_exec: assert property (valid_i && opc == PRA_FLOAT_GT_COUNTER_PUSH && src0_i == F_ZERO
    && src1_i == F_ONE |=> dst_o == F_ZERO && pred_exec_o && pred_wr_o)
    else $error("float gt push did not execute");
  a_uint_gt_set: assert property (valid_i && opc == PRA_UINT_GT_PREDICATE_SET
    |=> pred_exec_o == ($past(src0_i) > $past(src1_i)) && dst_o == (pred_exec_o ? F_ZERO : F_ONE))
    else $error("unsigned gt result wrong");
  a_int_gt_decode: assert property (valid_i && two_operand_control_word_i[OPC_LSB +: OPC_W] == 11'h043
    |=> valid_o && pred_wr_o && !illegal_o && pred_exec_o == ($signed($past(src0_i)) > $signed($past(src1_i))))
    else $error("opcode 67 not handled as signed gt");
  a_int_lt_push: assert property (valid_i && opc == PRA_INT_LT_COUNTER_PUSH && !src1_i[31]
    |=> !pred_exec_o && dst_o != F_ZERO)
    else $error("int lt push executed on non-negative src1");
  a_fne_nan_exec: assert property (valid_i && opc == PRA_FLOAT_NE_PREDICATE_SET && f_nan(src0_i)
    |=> pred_exec_o && dst_o == F_ZERO)
    else $error("float ne with NaN did not execute");
  a_recip_one_exact: assert property (valid_i && opc == PRA_SINGLE_RECIPROCAL_IEEE && src0_i == F_ONE
    |=> dst_o == F_ONE && !pred_wr_o)
    else $error("reciprocal of 1.0 not exact");
  a_recip_clamp_max: assert property (valid_i && opc == PRA_SINGLE_RECIPROCAL_CLAMP && src0_i[30:0] == 31'h0
    |=> dst_o == {$past(src0_i[31]), F_MAX_MAG})
    else $error("clamped reciprocal of zero not max float");
  a_recip_zero_clamp: assert property (valid_i && opc == PRA_SINGLE_RECIPROCAL_ZERO_CLAMP && src0_i[30:0] == 31'h0
    |=> dst_o == {$past(src0_i[31]), 31'h0})
    else $error("zero clamped reciprocal of zero not zero");
  a_drecip_one: assert property (valid_i && opc == PRA_DOUBLE_RECIPROCAL && src0_i == D_ONE_HI && src1_i == 32'h0
    |=> dst_o == D_ONE_HI)
    else $error("double reciprocal of 1.0 not exact");
  a_idle_no_pred: assert property (!valid_i |=> !valid_o && !pred_wr_o && $stable(dst_o))
    else $error("result changed without an instruction");

  // Execute and answer rules, then push, set and double results against their rules
  a_exec_needs_wr: assert property (pred_exec_o |-> pred_wr_o)
    else $error("execute shown without a predicate update");
  a_one_answer: assert property (valid_i |=> valid_o ^ illegal_o)
    else $error("instruction not answered exactly once");
  a_igt_push_exec: assert property (valid_i && opc == PRA_INT_GT_COUNTER_PUSH && src0_i == F_ZERO
    && $signed(src1_i) > 0 |=> pred_exec_o && dst_o == F_ZERO)
    else $error("int gt push did not execute");
  a_ile_push_exec: assert property (valid_i && opc == PRA_INT_LE_COUNTER_PUSH && src0_i == F_ZERO
    && src1_i == 32'h0 |=> pred_exec_o && dst_o == F_ZERO)
    else $error("int le push did not execute on zero");
  a_ine_set_exec: assert property (valid_i && opc == PRA_INT_NE_PREDICATE_SET
    |=> pred_wr_o && pred_exec_o == ($past(src0_i) != $past(src1_i)))
    else $error("int ne set result wrong");
  a_fne_push_skip: assert property (valid_i && opc == PRA_FLOAT_NE_COUNTER_PUSH && src0_i == 32'h4000_0000
    |=> !pred_exec_o && dst_o == 32'h4040_0000)
    else $error("float ne push did not count up from 2.0");
  a_ine_push_exec: assert property (valid_i && opc == PRA_INT_NE_COUNTER_PUSH && src0_i == F_ZERO
    && src1_i != 32'h0 |=> pred_exec_o && dst_o == F_ZERO)
    else $error("int ne push did not execute");
  a_drecip_clamp: assert property (valid_i && opc == PRA_DOUBLE_RECIPROCAL_CLAMP && src0_i[30:0] == 31'h0
    && src1_i == 32'h0 |=> dst_o == {$past(src0_i[31]), D_MAX_MAG})
    else $error("clamped double reciprocal of zero not max double");
  a_drsqrt_one: assert property (valid_i && opc == PRA_DOUBLE_RECIP_SQRT && src0_i == D_ONE_HI
    && src1_i == 32'h0 |=> dst_o == D_ONE_HI)
    else $error("double reciprocal square root of 1.0 not exact");
endmodule : pra_alu_slot
`default_nettype wire

// >>> verification/pra_seq_model.sv
/*
  Stand-in for the instruction sequencer and register file of the ALU slot.
  Assumes the bench changes its requests just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pra_seq_model (
  input  wire logic        clk_i,
  input  wire logic        issue_i,
  input  wire logic [10:0] opc_i,
  input  wire logic [6:0]  gpr_i,
  input  wire logic        last_i,
  input  wire logic [31:0] a_i,
  input  wire logic [31:0] b_i,
  input  wire logic [31:0] w_i,
  output logic             valid_o,
  output logic [31:0]      word0_o,
  output logic [31:0]      word1_o,
  output logic [31:0]      src0_o,
  output logic [31:0]      src1_o,
  output logic [31:0]      src0_w_o
);
  logic [31:0] a_r = '0;
  logic [31:0] b_r = '0;
  logic [31:0] w_r = '0;

  // Remember the last operands so idle lines can show their inverse
  always @(posedge clk_i) begin
    if (issue_i) begin
      a_r <= a_i;
      b_r <= b_i;
      w_r <= w_i;
    end
  end

  // Two words per instruction, operand selects first, control second
  assign valid_o  = issue_i;
  assign word0_o  = {last_i, 31'h0};
  assign word1_o  = {4'h0, gpr_i, 3'h0, opc_i, 7'h00};
  // Released operand lines carry no stale value
  assign src0_o   = issue_i ? a_i : ~a_r;
  assign src1_o   = issue_i ? b_i : ~b_r;
  assign src0_w_o = issue_i ? w_i : ~w_r;
endmodule : pra_seq_model
`default_nettype wire

// >>> verification/tb_predicate_and_reciprocal_alu_ops.sv
/*
  Self-checking bench for the predicate and reciprocal ALU slot.
  Assumes the slot answers one cycle after each accepted instruction.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_predicate_and_reciprocal_alu_ops;
  import pra_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        issue = 1'b0;
  logic        last  = 1'b0;
  logic [10:0] opc   = '0;
  logic [6:0]  gpr   = '0;
  logic [31:0] a     = '0;
  logic [31:0] b     = '0;
  logic [31:0] w     = '0;
  logic        vin, valid_o, last_o, pred_wr_o, pred_exec_o, illegal_o;
  logic [31:0] wd0, wd1, s0, s1, sw, dst_o;
  logic [6:0]  dst_gpr_o;
  int          err_count = 0;
  int          n_tests   = 0;
  int          cyc       = 0;

  pra_seq_model i_seq (.clk_i(clk_i), .issue_i(issue), .opc_i(opc), .gpr_i(gpr), .last_i(last),
    .a_i(a), .b_i(b), .w_i(w), .valid_o(vin), .word0_o(wd0), .word1_o(wd1), .src0_o(s0),
    .src1_o(s1), .src0_w_o(sw));
  pra_alu_slot i_dut (.clk_i(clk_i), .rst_i(rst_i), .valid_i(vin), .operand_select_word_i(wd0),
    .two_operand_control_word_i(wd1), .src0_i(s0), .src1_i(s1), .src0_w_i(sw),
    .valid_o(valid_o), .dst_o(dst_o), .dst_gpr_o(dst_gpr_o), .last_o(last_o),
    .pred_wr_o(pred_wr_o), .pred_exec_o(pred_exec_o), .illegal_o(illegal_o));

  // Clock and hang guard
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One instruction, then judge the registered answer
  task automatic op(input string nm, input logic [10:0] c, input logic [31:0] x, y, z,
                    input logic [31:0] d, input logic pw, input logic ex);
    @(posedge clk_i);
    issue <= 1'b1;
    opc   <= c;
    gpr   <= c[6:0] ^ 7'h2a;
    last  <= c[0];
    a     <= x;
    b     <= y;
    w     <= z;
    @(posedge clk_i);
    issue <= 1'b0;
    #1;
    chk({nm, ".dst"}, d, dst_o);
    chk({nm, ".valid"}, 32'h1, {31'h0, valid_o});
    chk({nm, ".pred_wr"}, {31'h0, pw}, {31'h0, pred_wr_o});
    chk({nm, ".exec"}, {31'h0, ex}, {31'h0, pred_exec_o});
    chk({nm, ".gpr"}, {25'h0, c[6:0] ^ 7'h2a}, {25'h0, dst_gpr_o});
    chk({nm, ".last"}, {31'h0, c[0]}, {31'h0, last_o});
  endtask : op

  task automatic t_reset();
    chk("rst.valid", 32'h0, {31'h0, valid_o});
    chk("rst.dst", 32'h0, dst_o);
    chk("rst.illegal", 32'h0, {31'h0, illegal_o});
    chk("rst.gpr", 32'h0, {25'h0, dst_gpr_o});
    chk("rst.exec", 32'h0, {31'h0, pred_exec_o});
    $display("test reset done");
  endtask : t_reset

  task automatic t_int_sets();
    op("ugt_big", 11'h01e, 32'hffff_ffff, 32'h1, 0, F_ZERO, 1, 1);
    op("ugt_eq", 11'h01e, 32'h3, 32'h3, 0, F_ONE, 1, 0);
    op("sgt_yes", 11'h043, 32'h5, 32'h3, 0, F_ZERO, 1, 1);
    op("sgt_neg", 11'h043, 32'hffff_ffff, 32'h1, 0, F_ONE, 1, 0);
    op("ine_diff", 11'h045, 32'h8000_0000, 32'h0, 0, F_ZERO, 1, 1);
    op("ine_same", 11'h045, 32'h7, 32'h7, 0, F_ONE, 1, 0);
    $display("test integer sets done");
  endtask : t_int_sets

  task automatic t_float_sets();
    op("fne_diff", 11'h023, F_ONE, 32'h4000_0000, 0, F_ZERO, 1, 1);
    op("fne_zero", 11'h023, F_ZERO, 32'h8000_0000, 0, F_ONE, 1, 0);
    op("fne_nan", 11'h023, F_QNAN, F_QNAN, 0, F_ZERO, 1, 1);
    op("fgtp_nan", 11'h029, F_ZERO, F_QNAN, F_ONE, 32'h4000_0000, 1, 0);
    $display("test float sets done");
  endtask : t_float_sets

  task automatic t_pushes();
    op("fgtp_ex", 11'h029, F_ZERO, F_ONE, 32'h4000_0000, F_ZERO, 1, 1);
    op("fgtp_sk", 11'h029, F_ZERO, F_ZERO, 32'h4000_0000, 32'h4040_0000, 1, 0);
    op("igtp_ex", 11'h04b, F_ZERO, 32'h1, 0, F_ZERO, 1, 1);
    op("igtp_sk", 11'h04b, F_ONE, 32'h1, 0, 32'h4000_0000, 1, 0);
    op("ilep_ex", 11'h04f, F_ZERO, 32'h0, 0, F_ZERO, 1, 1);
    op("ilep_sk", 11'h04f, F_ZERO, 32'h1, 0, F_ONE, 1, 0);
    op("iltp_ex", 11'h04e, F_ZERO, 32'hffff_ffff, 0, F_ZERO, 1, 1);
    op("iltp_sk", 11'h04e, F_ZERO, 32'h0, 0, F_ONE, 1, 0);
    op("fnep_ex", 11'h02b, F_ZERO, F_ONE, 0, F_ZERO, 1, 1);
    op("fnep_sk", 11'h02b, 32'h4000_0000, 32'h8000_0000, 0, 32'h4040_0000, 1, 0);
    op("inep_ex", 11'h04d, F_ZERO, 32'h1, 0, F_ZERO, 1, 1);
    op("inep_sk", 11'h04d, F_ONE, 32'h1, 0, 32'h4000_0000, 1, 0);
    $display("test pushes done");
  endtask : t_pushes

  task automatic t_recips();
    op("rcp_one", 11'h086, F_ONE, 0, 0, F_ONE, 0, 0);
    op("rcp_two", 11'h086, 32'h4000_0000, 0, 0, 32'h3f00_0000, 0, 0);
    op("rcpc_one", 11'h084, F_ONE, 0, 0, F_ONE, 0, 0);
    op("rcpc_two", 11'h084, 32'h4000_0000, 0, 0, 32'h3f00_0000, 0, 0);
    op("rcpc_pz", 11'h084, F_ZERO, 0, 0, 32'h7f7f_ffff, 0, 0);
    op("rcpc_nz", 11'h084, 32'h8000_0000, 0, 0, 32'hff7f_ffff, 0, 0);
    op("rcpz_pz", 11'h085, F_ZERO, 0, 0, 32'h0000_0000, 0, 0);
    op("rcpz_nz", 11'h085, 32'h8000_0000, 0, 0, 32'h8000_0000, 0, 0);
    op("drcp_one", 11'h095, D_ONE_HI, 0, 0, D_ONE_HI, 0, 0);
    op("drcp_two", 11'h095, 32'h4000_0000, 0, 0, 32'h3fe0_0000, 0, 0);
    op("drcp_lo", 11'h095, D_ONE_HI, 32'h1, 0, 32'h3fef_ffff, 0, 0);
    op("drcpc_pz", 11'h096, 0, 0, 0, 32'h7fef_ffff, 0, 0);
    op("drcpc_nz", 11'h096, 32'h8000_0000, 0, 0, 32'hffef_ffff, 0, 0);
    op("drsq_one", 11'h097, D_ONE_HI, 0, 0, D_ONE_HI, 0, 0);
    $display("test reciprocals done");
  endtask : t_recips

  // Reset in mid-run clears a result left by an earlier instruction
  task automatic t_mid_reset();
    op("pre_rst", 11'h086, 32'h4000_0000, 0, 0, 32'h3f00_0000, 0, 0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    t_reset();
  endtask : t_mid_reset

  task automatic t_illegal();
    @(posedge clk_i);
    issue <= 1'b1;
    opc   <= 11'h044;
    a     <= F_ONE;
    @(posedge clk_i);
    issue <= 1'b0;
    #1;
    chk("ill.flag", 32'h1, {31'h0, illegal_o});
    chk("ill.valid", 32'h0, {31'h0, valid_o});
    chk("ill.pred_wr", 32'h0, {31'h0, pred_wr_o});
    chk("ill.dst", F_ONE, dst_o);  // Out-of-group opcode still writes the reciprocal path result
    $display("test illegal done");
  endtask : t_illegal

  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    t_reset();
    t_int_sets();
    t_float_sets();
    t_pushes();
    t_recips();
    t_mid_reset();
    t_illegal();
    conclude();
  end
endmodule : tb_predicate_and_reciprocal_alu_ops
`default_nettype wire
